/* File: core/wcm_defines.svh */
// register map, field positions, reset values and timing counts
`ifndef WCM_DEFINES_SVH
`define WCM_DEFINES_SVH

// register addresses
`define WCM_ADDR_MODE_PLL_A  3'h0
`define WCM_ADDR_MULT_PLL_B  3'h1
`define WCM_ADDR_DIV_A       3'h2
`define WCM_ADDR_DIV_B       3'h3
`define WCM_ADDR_OUT_EN      3'h4
`define WCM_NUM_REGS         3'h5

// field positions
`define WCM_PLL_EN_BIT       0
`define WCM_CFG_HI           4
`define WCM_CFG_LO           1
`define WCM_MULT_HI          4
`define WCM_MULT_LO          1
`define WCM_OE_FRAME_BIT     4
`define WCM_OE_A_BIT         3
`define WCM_OE_B_BIT         2
`define WCM_LOCK_B_BIT       1
`define WCM_LOCK_A_BIT       0

// values
`define WCM_REG_RESET        5'h00
`define WCM_CFG_E1_T1        4'h8
`define WCM_MULT_ONE         4'h0
`define WCM_DIV_FWD          5'h1F
`define WCM_OE_ALL           5'h1F

// serial frame: rw, addr[2:0], data[4:0], msb first
`define WCM_FRAME_BITS       4'h9
`define WCM_HDR_BITS         4'h4
`define WCM_SCLK_HALF_M1     3'h3

`endif

/* File: core/wcm_pkg.sv */
// shared types of the clock mode configuration block
package wcm_pkg;

   typedef enum logic [1:0] {
      wcm_mode_other,
      wcm_mode_e1_t1_fwd,
      wcm_mode_rev_slave
   } wcm_mode_t;

   typedef enum logic [1:0] {
      wcm_host_idle,
      wcm_host_shift,
      wcm_host_done
   } wcm_host_st_t;

endpackage : wcm_pkg

/* File: core/wcm_link_if.sv */
// serial command link between host and configuration device
`timescale 1ns/1ps
interface wcm_link_if;
   logic rate_family_select;  // master select pin, high = master
   logic cs_n;                // frame select, active low
   logic sclk;                // serial clock made by host
   logic sdi;                 // host to device data
   logic sdo;                 // device to host data
   logic sdo_oe;              // device drives sdo
   logic sdo_line;            // resolved wire level

   // undriven line reads low, as with a pull-down
   assign sdo_line = sdo_oe & sdo;

   modport device (
      input  rate_family_select,
      input  cs_n,
      input  sclk,
      input  sdi,
      output sdo,
      output sdo_oe
   );

   modport host (
      output rate_family_select,
      output cs_n,
      output sclk,
      output sdi,
      input  sdo_line
   );
endinterface : wcm_link_if

/* File: core/wcm_device.sv */
// configuration device: serial register slave, mode decode, output gating
`timescale 1ns/1ps
// How it works
// - select pin high means master, full-rate reference
// - select pin low means slave, 8kHz reference
// - master with code 1000 gives E1-to-T1 forward
// - slave with code 1000 gives reverse slave
// - register zero D0 enables first PLL
// - register one D4-D1 hold multiple minus one
// - register one D0 enables second PLL
// - host writes 11111 to registers two, three in master mode
// - reverse slave ignores registers two and three
// - host writes 0000 multiple in slave mode
// - register four D4-D2 gate sync, outputs
// - register four D1, D0 enable lock indication
// - lock output: both, first, second, or low
`include "wcm_defines.svh"
module wcm_device (
   input  wire logic         core_clk,               // 125 MHz clock
   input  wire logic         arst_n,                 // async reset
   wcm_link_if.device        ser,                    // serial port pins
   input  wire logic         pll_a_locked,           // first pll lock
   input  wire logic         pll_b_locked,           // second pll lock
   output wcm_pkg::wcm_mode_t mode,                  // decoded mode
   output logic              master_mode,            // full-rate ref
   output logic              ref_is_8khz,            // 8kHz ref expected
   output logic              first_pll_enable,       // pll a running
   output logic              second_pll_enable,      // pll b running
   output logic [3:0]        ref_multiple,           // q minus one
   output logic [4:0]        divider_a,              // effective div a
   output logic [4:0]        divider_b,              // effective div b
   output logic              divider_used,           // div regs in use
   output logic              frame_pulse_out_enable, // sync driver on
   output logic              output_a_enable,        // out a driver on
   output logic              output_b_enable,        // out b driver on
   output logic              lock_indicator_output   // lock pin level
);

   typedef struct packed {
      logic [4:0][4:0]    regs;     // command registers 0..4
      logic               sclk_q;   // previous serial clock
      logic [3:0]         cnt;      // bits taken this frame
      logic [8:0]         shf;      // incoming frame bits
      logic               rd_act;   // frame is a read
      logic [4:0]         rd;       // read data to shift out
      logic               sdo;
      logic               sdo_oe;
      wcm_pkg::wcm_mode_t mode;
      logic               master;
      logic               ref8k;    // slow reference expected
      logic               pll_a;
      logic               pll_b;
      logic [3:0]         mult;
      logic [4:0]         div_a;
      logic [4:0]         div_b;
      logic               div_used;
      logic               oe_frame;
      logic               oe_a;
      logic               oe_b;
      logic               lock;
   } wcm_dev_state_t;

   wcm_dev_state_t s;
   wcm_dev_state_t n;

   // register read; unmapped addresses read as zero
   function automatic logic [4:0] wcm_read(
      input logic [4:0][4:0] regs,
      input logic [2:0]      addr
   );
      if (addr < `WCM_NUM_REGS) begin
         wcm_read = regs[addr];
      end else begin
         wcm_read = 5'h00;
      end
   endfunction : wcm_read

   // lock pin function picked by the two lock control bits
   function automatic logic wcm_lock(
      input logic [1:0] sel,
      input logic       en_a,
      input logic       en_b,
      input logic       lk_a,
      input logic       lk_b
   );
      case (sel)
         2'h3: begin
            // one disabled pll does not hold the pin low; with both disabled the pin is low
            wcm_lock = (en_a | en_b) & (~en_a | lk_a) & (~en_b | lk_b);
         end
         2'h1: begin
            wcm_lock = lk_a;
         end
         2'h2: begin
            wcm_lock = lk_b;
         end
         default: begin
            wcm_lock = 1'b0;
         end
      endcase
   endfunction : wcm_lock

   // next state: serial shifter, register writes, mode decode
   always_comb begin
      n = s;
      n.sclk_q = ser.sclk;
      if (ser.cs_n) begin
         // frame ended: drop the shifter and release sdo
         n.cnt    = 4'h0;
         n.rd_act = 1'b0;
         n.sdo    = 1'b0;
         n.sdo_oe = 1'b0;
      end else if (ser.sclk && !s.sclk_q
                   && s.cnt != `WCM_FRAME_BITS) begin
         // rising edge: take one bit
         n.cnt = s.cnt + 4'h1;
         n.shf = {s.shf[7:0], ser.sdi};
         if (s.cnt == `WCM_HDR_BITS - 4'h1 && s.shf[2]) begin
            n.rd_act = 1'b1;
            n.rd     = wcm_read(s.regs, {s.shf[1:0], ser.sdi});
         end
         if (s.cnt == `WCM_FRAME_BITS - 4'h1 && !s.shf[7]
             && s.shf[6:4] < `WCM_NUM_REGS) begin
            n.regs[s.shf[6:4]] = {s.shf[3:0], ser.sdi};
         end
      end else if (!ser.sclk && s.sclk_q && s.rd_act) begin
         // falling edge: present the next read bit
         if (s.cnt == `WCM_FRAME_BITS) begin
            n.sdo_oe = 1'b0;
            n.sdo    = 1'b0;
         end else begin
            n.sdo_oe = 1'b1;
            n.sdo    = s.rd[4];
            n.rd     = {s.rd[3:0], 1'b0};
         end
      end

      // mode follows the pin and register zero every cycle
      n.master = ser.rate_family_select;
      // own flop so the pin stays low, not high, while in reset
      n.ref8k  = ~ser.rate_family_select;
      if (n.regs[`WCM_ADDR_MODE_PLL_A][`WCM_CFG_HI:`WCM_CFG_LO]
          == `WCM_CFG_E1_T1) begin
         if (ser.rate_family_select) begin
            n.mode = wcm_pkg::wcm_mode_e1_t1_fwd;
         end else begin
            n.mode = wcm_pkg::wcm_mode_rev_slave;
         end
      end else begin
         n.mode = wcm_pkg::wcm_mode_other;
      end

      n.pll_a = n.regs[`WCM_ADDR_MODE_PLL_A][`WCM_PLL_EN_BIT];
      n.pll_b = n.regs[`WCM_ADDR_MULT_PLL_B][`WCM_PLL_EN_BIT];
      n.mult  = n.regs[`WCM_ADDR_MULT_PLL_B]
                      [`WCM_MULT_HI:`WCM_MULT_LO];

      // divider registers have no say in reverse slave
      if (n.mode == wcm_pkg::wcm_mode_rev_slave) begin
         n.div_a    = 5'h00;
         n.div_b    = 5'h00;
         n.div_used = 1'b0;
      end else begin
         n.div_a    = n.regs[`WCM_ADDR_DIV_A];
         n.div_b    = n.regs[`WCM_ADDR_DIV_B];
         n.div_used = 1'b1;
      end

      // a driver needs its enable bit and, for clocks, its pll
      n.oe_frame = n.regs[`WCM_ADDR_OUT_EN][`WCM_OE_FRAME_BIT];
      n.oe_a = n.regs[`WCM_ADDR_OUT_EN][`WCM_OE_A_BIT] & n.pll_a;
      n.oe_b = n.regs[`WCM_ADDR_OUT_EN][`WCM_OE_B_BIT] & n.pll_b;
      n.lock = wcm_lock(
         {n.regs[`WCM_ADDR_OUT_EN][`WCM_LOCK_B_BIT],
          n.regs[`WCM_ADDR_OUT_EN][`WCM_LOCK_A_BIT]},
         n.pll_a, n.pll_b, pll_a_locked, pll_b_locked);
   end

   // state register; registers clear so every driver starts off
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s.regs     <= {5{`WCM_REG_RESET}};
         s.sclk_q   <= 1'b0;
         s.cnt      <= 4'h0;
         s.shf      <= 9'h000;
         s.rd_act   <= 1'b0;
         s.rd       <= 5'h00;
         s.sdo      <= 1'b0;
         s.sdo_oe   <= 1'b0;
         s.mode     <= wcm_pkg::wcm_mode_other;
         s.master   <= 1'b0;
         s.ref8k    <= 1'b0;
         s.pll_a    <= 1'b0;
         s.pll_b    <= 1'b0;
         s.mult     <= 4'h0;
         s.div_a    <= 5'h00;
         s.div_b    <= 5'h00;
         s.div_used <= 1'b0;
         s.oe_frame <= 1'b0;
         s.oe_a     <= 1'b0;
         s.oe_b     <= 1'b0;
         s.lock     <= 1'b0;
      end else begin
         s <= n;
      end
   end

   // outputs straight from the state register
   assign ser.sdo                = s.sdo;
   assign ser.sdo_oe             = s.sdo_oe;
   assign mode                   = s.mode;
   assign master_mode            = s.master;
   assign ref_is_8khz            = s.ref8k;
   assign first_pll_enable       = s.pll_a;
   assign second_pll_enable      = s.pll_b;
   assign ref_multiple           = s.mult;
   assign divider_a              = s.div_a;
   assign divider_b              = s.div_b;
   assign divider_used           = s.div_used;
   assign frame_pulse_out_enable = s.oe_frame;
   assign output_a_enable        = s.oe_a;
   assign output_b_enable        = s.oe_b;
   assign lock_indicator_output  = s.lock;

endmodule : wcm_device

/* File: core/wcm_host.sv */
// host end: drives select pin, serial frames and the 1.544MHz preset
`timescale 1ns/1ps
`include "wcm_defines.svh"
module wcm_host (
   input  wire logic        core_clk,    // 125 MHz clock
   input  wire logic        arst_n,      // async reset
   wcm_link_if.host         ser,         // serial port pins
   input  wire logic        master_sel,  // wanted select pin level
   input  wire logic        cmd_valid,   // command request
   input  wire logic        cmd_write,   // 1 write, 0 read
   input  wire logic [2:0]  cmd_addr,    // register address
   input  wire logic [4:0]  cmd_wdata,   // write data
   output logic             cmd_ready,   // command accepted when high
   output logic             rsp_valid,   // one-cycle completion
   output logic [4:0]       rsp_rdata,   // read data
   input  wire logic        preset_go,   // start preset sequence
   input  wire logic [3:0]  preset_q_m1, // reference multiple minus one
   output logic             preset_busy  // preset in progress
);

   typedef struct packed {
      wcm_pkg::wcm_host_st_t st;
      logic [2:0]  div;
      logic        sclk;
      logic        cs_n;
      logic        sdi;
      logic [3:0]  idx;
      logic [8:0]  frame;
      logic        from_cmd;
      logic [4:0]  rdata;
      logic        ready;
      logic        rsp_valid;
      logic [4:0]  rsp_rdata;
      logic        msel;
      logic        pre_act;
      logic [2:0]  pre_step;
   } wcm_host_state_t;

   wcm_host_state_t s;
   wcm_host_state_t n;
   logic [9:0]      pre;

   // preset steps as {last, write frame}
   function automatic logic [9:0] wcm_preset(
      input logic [2:0] step,
      input logic       master,
      input logic [3:0] q_m1
   );
      logic [3:0] mult;
      mult = master ? q_m1 : `WCM_MULT_ONE;
      case (step)
         3'h0: begin
            wcm_preset = {2'b00, `WCM_ADDR_MODE_PLL_A,
                          `WCM_CFG_E1_T1, 1'b1};
         end
         3'h1: begin
            wcm_preset = {2'b00, `WCM_ADDR_MULT_PLL_B,
                          mult, 1'b1};
         end
         3'h2: begin
            // slave mode skips the divider registers
            wcm_preset = master
               ? {2'b00, `WCM_ADDR_DIV_A, `WCM_DIV_FWD}
               : {2'b10, `WCM_ADDR_OUT_EN, `WCM_OE_ALL};
         end
         3'h3: begin
            wcm_preset = {2'b00, `WCM_ADDR_DIV_B, `WCM_DIV_FWD};
         end
         default: begin
            wcm_preset = {2'b10, `WCM_ADDR_OUT_EN, `WCM_OE_ALL};
         end
      endcase
   endfunction : wcm_preset

   assign pre = wcm_preset(s.pre_step, s.msel, preset_q_m1);

   // next state: command pick, bit shifting, completion
   always_comb begin
      n = s;
      n.msel      = master_sel;
      n.rsp_valid = 1'b0;
      case (s.st)
         wcm_pkg::wcm_host_idle: begin
            if (cmd_valid && s.ready) begin
               n.frame    = {~cmd_write, cmd_addr, cmd_wdata};
               n.from_cmd = 1'b1;
               n.st       = wcm_pkg::wcm_host_shift;
            end else if (s.pre_act) begin
               n.frame    = pre[8:0];
               n.from_cmd = 1'b0;
               n.st       = wcm_pkg::wcm_host_shift;
            end else if (preset_go) begin
               n.pre_act  = 1'b1;
               n.pre_step = 3'h0;
            end
            if (n.st == wcm_pkg::wcm_host_shift) begin
               n.ready = 1'b0;
               n.cs_n  = 1'b0;
               n.sdi   = n.frame[8];
               n.idx   = 4'h0;
               n.div   = 3'h0;
               n.sclk  = 1'b0;
            end else begin
               n.ready = ~n.pre_act;
            end
         end
         wcm_pkg::wcm_host_shift: begin
            // sclk toggles every half period of core cycles
            n.div = s.div + 3'h1;
            if (s.div == `WCM_SCLK_HALF_M1) begin
               n.div  = 3'h0;
               n.sclk = ~s.sclk;
               if (!s.sclk) begin
                  if (s.frame[8] && s.idx >= `WCM_HDR_BITS) begin
                     n.rdata = {s.rdata[3:0], ser.sdo_line};
                  end
                  n.idx = s.idx + 4'h1;
               end else if (s.idx == `WCM_FRAME_BITS) begin
                  n.cs_n = 1'b1;
                  n.st   = wcm_pkg::wcm_host_done;
               end else begin
                  n.sdi = s.frame[4'h8 - s.idx];
               end
            end
         end
         default: begin
            // cs_n stays high here, so frames are never merged
            n.sdi = 1'b0;
            if (s.from_cmd) begin
               n.rsp_valid = 1'b1;
               n.rsp_rdata = s.frame[8] ? s.rdata : 5'h00;
            end else if (pre[9]) begin
               n.pre_act = 1'b0;
            end else begin
               n.pre_step = s.pre_step + 3'h1;
            end
            n.ready = ~n.pre_act;
            n.st    = wcm_pkg::wcm_host_idle;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s.st        <= wcm_pkg::wcm_host_idle;
         s.div       <= 3'h0;
         s.sclk      <= 1'b0;
         s.cs_n      <= 1'b1;
         s.sdi       <= 1'b0;
         s.idx       <= 4'h0;
         s.frame     <= 9'h000;
         s.from_cmd  <= 1'b0;
         s.rdata     <= 5'h00;
         s.ready     <= 1'b0;
         s.rsp_valid <= 1'b0;
         s.rsp_rdata <= 5'h00;
         s.msel      <= 1'b0;
         s.pre_act   <= 1'b0;
         s.pre_step  <= 3'h0;
      end else begin
         s <= n;
      end
   end

   assign ser.rate_family_select = s.msel;
   assign ser.cs_n               = s.cs_n;
   assign ser.sclk               = s.sclk;
   assign ser.sdi                = s.sdi;
   assign cmd_ready              = s.ready;
   assign rsp_valid              = s.rsp_valid;
   assign rsp_rdata              = s.rsp_rdata;
   assign preset_busy            = s.pre_act;

endmodule : wcm_host

/* File: test/wcm_assertions.sv */
// concurrent checks on the serial link and the decoded device outputs
`timescale 1ns/1ps
module wcm_assertions (
   input wire logic         core_clk,           // 125 MHz clock
   input wire logic         arst_n,             // async reset
   input wire logic         rate_family_select, // select pin
   input wire logic         cs_n,               // frame select
   input wire logic         sclk,               // serial clock
   input wire logic         sdo_oe,             // device drives sdo
   input wcm_pkg::wcm_mode_t mode,              // decoded mode
   input wire logic         master_mode,        // full-rate ref
   input wire logic         ref_is_8khz,        // 8kHz ref
   input wire logic         first_pll_enable,   // pll a on
   input wire logic         second_pll_enable,  // pll b on
   input wire logic         output_a_enable,    // out a driver
   input wire logic         output_b_enable,    // out b driver
   input wire logic [4:0]   divider_a,          // effective div a
   input wire logic [4:0]   divider_b,          // effective div b
   input wire logic         divider_used        // div regs in use
);
   // every check lives in the one core clock domain
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   pin_track_a: assert property (
      master_mode == $past(rate_family_select))
      else $error("master mode does not follow select pin");
   ref_rate_a: assert property (
      $past(arst_n) |-> ref_is_8khz == !master_mode)
      else $error("reference rate flag disagrees with mode");
   fwd_mode_a: assert property (
      mode == wcm_pkg::wcm_mode_e1_t1_fwd |-> master_mode && divider_used)
      else $error("forward mode without master select");
   rev_mode_a: assert property (
      mode == wcm_pkg::wcm_mode_rev_slave |-> !master_mode && ref_is_8khz)
      else $error("reverse mode without slave select");
   out_a_gate_a: assert property (
      output_a_enable |-> first_pll_enable)
      else $error("output a driven with pll a off");
   out_b_gate_a: assert property (
      output_b_enable |-> second_pll_enable)
      else $error("output b driven with pll b off");
   div_ignore_a: assert property (
      mode == wcm_pkg::wcm_mode_rev_slave |->
         divider_a == 5'h00 && divider_b == 5'h00 && !divider_used)
      else $error("divider registers used in reverse mode");
   sdo_release_a: assert property (
      cs_n ##1 cs_n |-> !sdo_oe)
      else $error("data out still driven outside a frame");
   sclk_half_a: assert property (
      $rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("serial clock high phase not four cycles");
   frame_lead_a: assert property (
      $fell(cs_n) |-> !sclk [*4] ##1 sclk)
      else $error("first serial clock rise misplaced");
endmodule : wcm_assertions

/* File: test/wcm_mode_config_tb.sv */
// self-checking bench: host and device joined over the serial link
`timescale 1ns/1ps
module wcm_mode_config_tb;
   logic               core_clk, arst_n, master_sel, preset_go, preset_busy;
   logic               cmd_valid, cmd_write, cmd_ready, rsp_valid;
   logic [2:0]         cmd_addr, a;
   logic [4:0]         cmd_wdata, rsp_rdata, d, rd;
   logic [3:0]         preset_q_m1, ref_multiple;
   logic               pll_a_locked, pll_b_locked, master_mode, ref_is_8khz;
   logic               first_pll_enable, second_pll_enable, divider_used;
   logic               frame_pulse_out_enable, output_a_enable;
   logic               output_b_enable, lock_indicator_output;
   logic [4:0]         divider_a, divider_b;
   wcm_pkg::wcm_mode_t mode;
   logic [4:0]         mdl [0:4];
   logic [7:0]         rnd;
   int                 num_errors, total_checks, n;

   wcm_link_if link ();
   wcm_device u_wcm_device (.core_clk(core_clk), .arst_n(arst_n),
      .ser(link), .pll_a_locked(pll_a_locked), .pll_b_locked(pll_b_locked),
      .mode(mode), .master_mode(master_mode), .ref_is_8khz(ref_is_8khz),
      .first_pll_enable(first_pll_enable),
      .second_pll_enable(second_pll_enable), .ref_multiple(ref_multiple),
      .divider_a(divider_a), .divider_b(divider_b),
      .divider_used(divider_used),
      .frame_pulse_out_enable(frame_pulse_out_enable),
      .output_a_enable(output_a_enable), .output_b_enable(output_b_enable),
      .lock_indicator_output(lock_indicator_output));
   wcm_host u_wcm_host (.core_clk(core_clk), .arst_n(arst_n), .ser(link),
      .master_sel(master_sel), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .preset_go(preset_go), .preset_q_m1(preset_q_m1),
      .preset_busy(preset_busy));
   wcm_assertions u_wcm_assertions (.core_clk(core_clk), .arst_n(arst_n),
      .rate_family_select(link.rate_family_select), .cs_n(link.cs_n),
      .sclk(link.sclk), .sdo_oe(link.sdo_oe), .mode(mode),
      .master_mode(master_mode), .ref_is_8khz(ref_is_8khz),
      .first_pll_enable(first_pll_enable),
      .second_pll_enable(second_pll_enable),
      .output_a_enable(output_a_enable), .output_b_enable(output_b_enable),
      .divider_a(divider_a), .divider_b(divider_b),
      .divider_used(divider_used));

   // free-running 8 ns clock
   initial core_clk = 1'b0;
   always #4 core_clk = ~core_clk;

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   function automatic wcm_pkg::wcm_mode_t exp_mode(input logic pin,
                                                 input logic [4:0] r0);
      if (r0[4:1] != 4'h8) return wcm_pkg::wcm_mode_other;
      return pin ? wcm_pkg::wcm_mode_e1_t1_fwd : wcm_pkg::wcm_mode_rev_slave;
   endfunction : exp_mode

   // lock pin: both enabled plls, a only, b only, or held low
   function automatic logic exp_lock(input logic [4:0] r4, input logic ea,
                                     input logic eb, input logic la,
                                     input logic lb);
      case (r4[1:0])
         2'h3: return (ea | eb) & (!ea | la) & (!eb | lb);
         2'h1: return la;
         2'h2: return lb;
         default: return 1'b0;
      endcase
   endfunction : exp_lock

   task automatic results;
      if (num_errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // inputs always move 1 ns after the rising edge
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic give_up(input int k);
      if (k >= 1000) begin
         num_errors++;
         results();
      end
   endtask : give_up

   // one command: hold valid over the edge where ready is high
   task automatic bus_op(input logic wr, input logic [2:0] ad,
                         input logic [4:0] wd, output logic [4:0] q);
      for (n = 0; n < 1000 && cmd_ready !== 1'b1; n++) tick(1);
      give_up(n);
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = ad;
      cmd_wdata = wd;
      tick(1);
      cmd_valid = 1'b0;
      for (n = 0; n < 1000 && rsp_valid !== 1'b1; n++) tick(1);
      give_up(n);
      q = rsp_rdata;
      if (wr && ad < 3'h5) mdl[ad] = wd;
   endtask : bus_op

   // decode settles two cycles after a select change, three are allowed
   task automatic check_all;
      logic rev;
      tick(3);
      rev = exp_mode(master_sel, mdl[0]) == wcm_pkg::wcm_mode_rev_slave;
      check("mode", mode, exp_mode(master_sel, mdl[0]));
      check("master", master_mode, master_sel);
      check("ref8k", ref_is_8khz, !master_sel);
      check("pll_a", first_pll_enable, mdl[0][0]);
      check("pll_b", second_pll_enable, mdl[1][0]);
      check("mult", ref_multiple, mdl[1][4:1]);
      check("div_a", divider_a, rev ? 5'h00 : mdl[2]);
      check("div_b", divider_b, rev ? 5'h00 : mdl[3]);
      check("div_used", divider_used, !rev);
      check("frame_en", frame_pulse_out_enable, mdl[4][4]);
      check("out_a_en", output_a_enable, mdl[4][3] & mdl[0][0]);
      check("out_b_en", output_b_enable, mdl[4][2] & mdl[1][0]);
      check("lock", lock_indicator_output, exp_lock(mdl[4], mdl[0][0],
            mdl[1][0], pll_a_locked, pll_b_locked));
   endtask : check_all

   // main sequence
   initial begin
      num_errors = 0;
      total_checks = 0;
      arst_n = 1'b0;
      master_sel = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr = 3'h0;
      cmd_wdata = 5'h00;
      preset_go = 1'b0;
      preset_q_m1 = 4'h0;
      pll_a_locked = 1'b0;
      pll_b_locked = 1'b0;
      rnd = 8'h33;
      for (int i = 0; i < 5; i++) mdl[i] = 5'h00;
      repeat (5) @(posedge core_clk);
      #1 arst_n = 1'b1;
      tick(2);
      // reset values, unmapped places read as zero
      for (int i = 0; i < 8; i++) begin
         bus_op(1'b0, 3'(i), 5'h00, rd);
         check("reset_rd", rd, 5'h00);
      end
      check_all();
      // random writes, every third one aims a mode code at register zero
      for (int i = 0; i < 30; i++) begin
         rnd = lfsr(rnd);
         master_sel = rnd[7];
         pll_a_locked = rnd[6];
         pll_b_locked = rnd[5];
         a = (i % 3 == 0) ? 3'h0 : rnd[2:0];
         rnd = lfsr(rnd);
         d = (i % 3 == 0) ? {4'h8, rnd[0]} : rnd[4:0];
         bus_op(1'b1, a, d, rd);
         bus_op(1'b0, a, 5'h00, rd);
         check("readback", rd, (a < 3'h5) ? d : 5'h00);
         check_all();
      end
      // every lock select code, then the pin alone flips the mode
      bus_op(1'b1, 3'h0, 5'h11, rd);
      for (int s = 0; s < 4; s++) begin
         rnd = lfsr(rnd);
         pll_a_locked = rnd[1];
         pll_b_locked = rnd[2];
         bus_op(1'b1, 3'h4, {3'h7, 2'(s)}, rd);
         master_sel = rnd[s];
         check_all();
         master_sel = !master_sel;
         check_all();
      end
      // host preset in master and then slave selection
      for (int p = 1; p >= 0; p--) begin
         rnd = lfsr(rnd);
         master_sel = p[0];
         preset_q_m1 = rnd[3:0];
         preset_go = 1'b1;
         tick(1);
         preset_go = 1'b0;
         check("busy", preset_busy, 1'b1);
         for (n = 0; n < 1000 && preset_busy !== 1'b0; n++) tick(1);
         give_up(n);
         mdl[0] = 5'h11;
         mdl[1] = p ? {rnd[3:0], 1'b1} : 5'h01;
         mdl[4] = 5'h1F;
         if (p) mdl[2] = 5'h1F;
         if (p) mdl[3] = 5'h1F;
         check_all();
         bus_op(1'b0, 3'h3, 5'h00, rd);
         check("div_b_rd", rd, mdl[3]);
         bus_op(1'b0, 3'h1, 5'h00, rd);
         check("mult_rd", rd, mdl[1]);
      end
      results();
   end
endmodule : wcm_mode_config_tb
